// File: sr_ctrl_map.svh
// Constants for the self refresh control block
`ifndef SR_CTRL_MAP_SVH
`define SR_CTRL_MAP_SVH
// Mode register 2 field positions
`define MR2_AUTO_TEMP_BIT 6
`define MR2_MANUAL_TEMP_BIT 7
// Command encodings {cs_n, ras_n, cas_n, we_n}
`define CMD_REFRESH 4'h1
`define CMD_NOP 4'h7
// Clock period in ns
`define CLK_PERIOD_NS 10
// Minimum CKE pulse time in ns, and internal refresh start bound in cycles
`define CKE_MIN_NS 8
`define CKE_MIN_CYC ((`CKE_MIN_NS) / (`CLK_PERIOD_NS) < 1 ? 1 : \
  (`CKE_MIN_NS) / (`CLK_PERIOD_NS))
// Exit time and DLL-lock exit time (ns), counted from the exit edge
`define XS_NS 170
`define XS_CYC (((`XS_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define XSDLL_NS 5120
`define XSDLL_CYC (((`XSDLL_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// Internal refresh interval in self refresh, normal and extended range
`define SR_REF_NORMAL_CYC 16'h0C30
`define SR_REF_EXT_CYC 16'h0618
`endif

// File: sr_ctrl_pkg.sv
// Types for the self refresh control block
package sr_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_SELF_REFRESH = 4'h2,
    ST_EXIT_WAIT = 4'h4,
    ST_DLL_WAIT = 4'h8
  } sr_state_e;

  typedef struct packed {
    sr_state_e state;
    logic [15:0] ref_cnt;
    logic [15:0] exit_cnt;
    logic dll_en;
    logic dll_reset;
    logic dll_locked;
    logic in_sr;
    logic int_ref;
    logic ext_range;
    logic illegal_cfg;
    logic cmd_accept;
  } sr_ctrl_s;
endpackage

// File: sr_ctrl.sv
// Self refresh entry, residency and exit control of a DDR3 device
// What this block does
// - REFRESH registered with CKE low is decoded as self refresh entry.
// - DLL disabled on entry; on exit enabled again and reset.
// - Device stays in self refresh while CKE stays low.
// - In self refresh commands are ignored; only CKE, reset and the range inputs (mode bits 6 and 7, hot) are heeded.
// - An internal refresh starts one cycle (10 ns) after entry, past the 8 ns minimum CKE pulse time; none if CKE is high at that edge.
// - Exit taken at first edge with CKE high; timers start there.
// - Mode bit 7 selects normal or extended range when automatic off.
// - Mode bit 6 set makes the refresh rate automatic.
`include "sr_ctrl_map.svh"

module sr_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire logic [3:0] cmd_in,
  input wire logic [7:0] mr2_in,
  input wire logic hot_in,
  output logic in_self_refresh_out,
  output logic dll_enable_out,
  output logic dll_reset_out,
  output logic dll_locked_out,
  output logic internal_refresh_out,
  output logic extended_range_out,
  output logic illegal_config_out,
  output logic cmd_accept_out
);

  sr_ctrl_pkg::sr_ctrl_s cur_reg;
  sr_ctrl_pkg::sr_ctrl_s cur_next;

  ////////////////////////////////////////////////////////////////////////////
  // Counter loads, cut to the counter width on purpose
  localparam logic [15:0] CKE_LOAD = 16'(`CKE_MIN_CYC - 1);
  localparam logic [15:0] XS_LOAD = 16'(`XS_CYC - 1);
  localparam logic [15:0] DLL_LOAD = 16'(`XSDLL_CYC - `XS_CYC - 1);

  // Both timers count from the exit edge: the exit wait runs XS_CYC
  // cycles, then the DLL wait runs the rest of XSDLL_CYC, so the lock
  // flag rises XSDLL_CYC cycles after the edge that saw CKE high.
  // A timer that reaches zero stays there rather than wrapping.

  function automatic logic [15:0] dec16(input logic [15:0] v);
    dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction

  // Entry is a refresh command taken with CKE low
  function automatic logic is_sr_entry(
    input logic cke,
    input logic [3:0] cmd
  );
    is_sr_entry = !cke && (cmd == `CMD_REFRESH);
  endfunction

  // Extended range: manual selection, or automatic mode while hot
  function automatic logic ext_range_sel(
    input logic [7:0] mr2,
    input logic hot
  );
    ext_range_sel = mr2[`MR2_MANUAL_TEMP_BIT] |
      (mr2[`MR2_AUTO_TEMP_BIT] & hot);
  endfunction

  // Automatic and manual range both set is not a legal setting
  function automatic logic illegal_sel(input logic [7:0] mr2);
    illegal_sel = mr2[`MR2_MANUAL_TEMP_BIT] & mr2[`MR2_AUTO_TEMP_BIT];
  endfunction

  // Internal refresh interval for the selected range
  function automatic logic [15:0] ref_interval(input logic ext);
    ref_interval = ext ? `SR_REF_EXT_CYC : `SR_REF_NORMAL_CYC;
  endfunction

  // State after reset, also the recovery from an unknown state code
  function automatic sr_ctrl_pkg::sr_ctrl_s reset_state();
    reset_state = '{
      state: sr_ctrl_pkg::ST_ACTIVE,
      ref_cnt: 16'h0000,
      exit_cnt: 16'h0000,
      dll_en: 1'b1,
      dll_reset: 1'b0,
      dll_locked: 1'b1,
      in_sr: 1'b0,
      int_ref: 1'b0,
      ext_range: 1'b0,
      illegal_cfg: 1'b0,
      cmd_accept: 1'b1
    };
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.int_ref = 1'b0;
    cur_next.dll_reset = 1'b0;
    // Rate selection from mode register 2
    cur_next.ext_range = ext_range_sel(mr2_in, hot_in);
    cur_next.illegal_cfg = illegal_sel(mr2_in);
    case (cur_reg.state)
      sr_ctrl_pkg::ST_ACTIVE:
      begin
        if (is_sr_entry(cke_in, cmd_in))
        begin
          cur_next.state = sr_ctrl_pkg::ST_SELF_REFRESH;
          cur_next.in_sr = 1'b1;
          cur_next.dll_en = 1'b0;
          cur_next.dll_locked = 1'b0;
          cur_next.cmd_accept = 1'b0;
          cur_next.ref_cnt = CKE_LOAD;
        end
      end

      sr_ctrl_pkg::ST_SELF_REFRESH:
      begin
        // Commands are ignored here; only CKE is looked at
        if (cke_in)
        begin
          cur_next.state = sr_ctrl_pkg::ST_EXIT_WAIT;
          cur_next.in_sr = 1'b0;
          cur_next.dll_en = 1'b1;
          cur_next.dll_reset = 1'b1;
          cur_next.exit_cnt = XS_LOAD;
          cur_next.ref_cnt = 16'h0000;
        end
        else if (cur_reg.ref_cnt == 16'h0000)
        begin
          cur_next.int_ref = 1'b1;
          cur_next.ref_cnt = ref_interval(cur_reg.ext_range);
        end
        else
        begin
          cur_next.ref_cnt = dec16(cur_reg.ref_cnt);
        end
      end

      sr_ctrl_pkg::ST_EXIT_WAIT:
      begin
        cur_next.exit_cnt = dec16(cur_reg.exit_cnt);
        if (cur_reg.exit_cnt == 16'h0000)
        begin
          cur_next.state = sr_ctrl_pkg::ST_DLL_WAIT;
          cur_next.cmd_accept = 1'b1;
          cur_next.exit_cnt = DLL_LOAD;
        end
      end

      sr_ctrl_pkg::ST_DLL_WAIT:
      begin
        cur_next.exit_cnt = dec16(cur_reg.exit_cnt);
        // Re-entry wins over the lock edge so that no entry is dropped
        if (is_sr_entry(cke_in, cmd_in))
        begin
          cur_next.state = sr_ctrl_pkg::ST_SELF_REFRESH;
          cur_next.in_sr = 1'b1;
          cur_next.dll_en = 1'b0;
          cur_next.cmd_accept = 1'b0;
          cur_next.ref_cnt = CKE_LOAD;
        end
        else if (cur_reg.exit_cnt == 16'h0000)
        begin
          cur_next.state = sr_ctrl_pkg::ST_ACTIVE;
          cur_next.dll_locked = 1'b1;
        end
      end

      default:
      begin
        cur_next = reset_state();
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cur_reg <= reset_state();
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a field of the state register
  assign in_self_refresh_out = cur_reg.in_sr;
  assign dll_enable_out = cur_reg.dll_en;
  assign dll_reset_out = cur_reg.dll_reset;
  assign dll_locked_out = cur_reg.dll_locked;
  assign internal_refresh_out = cur_reg.int_ref;
  assign extended_range_out = cur_reg.ext_range;
  assign illegal_config_out = cur_reg.illegal_cfg;
  assign cmd_accept_out = cur_reg.cmd_accept;

endmodule // sr_ctrl

// File: sr_ctrl_properties.sv
// Assertions on the self refresh block ports
module sr_ctrl_chk (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire logic [3:0] cmd_in,
  input wire logic [7:0] mr2_in,
  input wire logic hot_in,
  input wire logic in_self_refresh_out,
  input wire logic dll_enable_out,
  input wire logic dll_reset_out,
  input wire logic dll_locked_out,
  input wire logic internal_refresh_out,
  input wire logic extended_range_out,
  input wire logic illegal_config_out,
  input wire logic cmd_accept_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_exit; in_self_refresh_out && cke_in; endsequence
  // Cycles since the exit edge; cleared in self refresh, saturates
  logic [9:0] lock_cnt;
  always_ff @(posedge sys_clk_in)
    if (!rst_n_in) lock_cnt <= 10'h000;
    else if (in_self_refresh_out && cke_in) lock_cnt <= 10'h001;
    else if (in_self_refresh_out) lock_cnt <= 10'h000;
    else if (lock_cnt != 10'h000 && lock_cnt != 10'h3FF)
      lock_cnt <= lock_cnt + 10'h001;
  property p_entry; !cke_in && cmd_in == 4'h1 && cmd_accept_out
    |=> in_self_refresh_out; endproperty
  a_entry: assert property (p_entry) else $error("entry");
  property p_stay; in_self_refresh_out && !cke_in |=> in_self_refresh_out;
  endproperty
  a_stay: assert property (p_stay) else $error("stay");
  property p_exit; s_exit |=> !in_self_refresh_out; endproperty
  a_exit: assert property (p_exit) else $error("exit");
  property p_ref; $rose(in_self_refresh_out) |=> internal_refresh_out;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh");
  property p_deaf; in_self_refresh_out |=> !cmd_accept_out; endproperty
  a_deaf: assert property (p_deaf) else $error("accept");
  property p_xs; s_exit |-> ##17 !cmd_accept_out ##1 cmd_accept_out;
  endproperty
  a_xs: assert property (p_xs) else $error("exit time");
  property p_lock; lock_cnt == 10'h200 && !in_self_refresh_out
    && !(!cke_in && cmd_in == 4'h1)
    |-> !dll_locked_out ##1 dll_locked_out; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_dll_off; $rose(in_self_refresh_out) |-> !dll_enable_out;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("dll off");
  property p_dll_on; s_exit |=> dll_enable_out && dll_reset_out
    ##1 !dll_reset_out; endproperty
  a_dll_on: assert property (p_dll_on) else $error("dll on");
  property p_mode;
    ($stable(mr2_in) && $stable(hot_in) && $past(rst_n_in))[*2]
    |-> extended_range_out == (mr2_in[7] | mr2_in[6] & hot_in)
    && illegal_config_out == (mr2_in[6] & mr2_in[7]); endproperty
  a_mode: assert property (p_mode) else $error("mode");
endmodule // sr_ctrl_chk

bind sr_ctrl sr_ctrl_chk u_chk (.*);

// File: sr_host.sv
// Controller model driving clock enable and commands
module sr_host (
  input wire logic sys_clk_in,
  output logic cke_in,
  output logic [3:0] cmd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cke_in, cmd_in} = 5'h17;
  task automatic send(input logic k, input logic [3:0] c);
    @(negedge sys_clk_in);
    {cke_in, cmd_in} = {k, c};
  endtask
  // Banks idle and termination off; entry then one idle command
  task automatic enter; send(1'b0, 4'h1); send(1'b0, 4'h7);
  endtask
  // Commands are unconstrained in residency and keep changing
  task automatic hold(input int n); repeat (n) send(1'b0, cmd_in ^ 4'h6);
  endtask // (clock never stopped)
endmodule // sr_host

// File: test_sr_ctrl.sv
// Testbench of the self refresh block
module test_sr_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, rst_n_in, cke_in, hot_in;
  logic [3:0] cmd_in;
  logic [7:0] mr2_in;
  logic in_self_refresh_out, dll_enable_out, dll_reset_out, dll_locked_out;
  logic internal_refresh_out, extended_range_out, illegal_config_out;
  logic cmd_accept_out;
  int num_errors, checks, cyc, na, nl;
  sr_ctrl u_dut (.*);
  sr_host u_host (.*);
  initial
  begin
    sys_clk_in = 0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic got, exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: bit differs", $time);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk_in)
    if (++cyc == 6000)
    begin
      chk(1'b0, 1'b1);
      summarize;
    end
  task automatic enter;
    u_host.enter;
    chk(in_self_refresh_out & ~dll_enable_out, 1);
    @(negedge sys_clk_in);
    chk(internal_refresh_out, 1);
  endtask
  // Only idle commands until the exit time has run
  task automatic leave(input bit full);
    u_host.send(1'b1, 4'h7);
    @(negedge sys_clk_in);
    chk(dll_reset_out & dll_enable_out & ~in_self_refresh_out, 1);
    {na, nl} = 0;
    for (int k = 2; k < (full ? 520 : 19); k++)
    begin
      @(negedge sys_clk_in);
      if (cmd_accept_out === 1 && na == 0) na = k;
      if (dll_locked_out === 1 && nl == 0) nl = k;
    end
    chk(na == 18 && (nl == 513 || !full), 1);
  endtask
  initial
  begin
    {rst_n_in, hot_in, mr2_in} = 0;
    repeat (4) @(negedge sys_clk_in);
    rst_n_in = 1;
    chk(dll_locked_out & cmd_accept_out & ~in_self_refresh_out, 1);
    u_host.send(1'b1, 4'h1);
    u_host.send(1'b1, 4'h7);
    chk(in_self_refresh_out, 0);
    enter;
    u_host.hold(20);
    chk(in_self_refresh_out, 1);
    leave(0);
    enter;
    u_host.hold(600);
    leave(1);
    $display("entry and exit test done");
    for (int i = 0; i < 8; i++)
    begin
      {mr2_in, hot_in} = {i[1:0], 6'h00, i[2]};
      repeat (3) @(negedge sys_clk_in);
      chk(extended_range_out, i[1] | i[0] & i[2]);
      chk(illegal_config_out, i[1] & i[0]);
    end
    $display("mode test done"); // (bench issues one external refresh, right after reset)
    summarize;
  end
endmodule // test_sr_ctrl
